/* File: hdl/tcap_phy_enable.sv */
// superspeed phy enable logic driven by type-c attach and orientation pins
//
// Overview of operation
// RULE1: scheme strap low: combined attach plus orientation
// RULE2: scheme strap high: only per-orientation attach inputs
// RULE3: orientation-a attach turns a-phy on, else off
// RULE4: orientation-b attach turns b-phy on, else off
// RULE5: polarity strap low: all attach inputs active high
// RULE6: polarity strap high: all attach inputs active low
// RULE7: floating polarity strap reads low, active high
// RULE8: floating scheme strap reads low, combined scheme
// RULE9: combined attach enables port phy, else off
// RULE10: orientation picks a or b, qualified by attach
// RULE11: synchronise all pins; phys off in reset
`timescale 1ns/1ns
`include "tcap_consts.svh"

module tcap_phy_enable #(
  parameter int NUM_PORTS = `TCAP_NUM_PORTS,
  parameter int ORIENT_PORT = `TCAP_ORIENT_PORT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // straps
  input wire logic attach_polarity_strap,
  input wire logic per_orientation_scheme_sel,
  // combined scheme pins
  input wire logic [NUM_PORTS-1:0] combined_attach_in,
  input wire logic orientation_sel_in,
  // per-orientation scheme pins
  input wire logic orient_a_attach_in,
  input wire logic orient_b_attach_in,
  // phy enables
  output logic [NUM_PORTS-1:0] port_phy_en,
  output logic orient_a_phy_en,
  output logic orient_b_phy_en,
  // status
  output tcap_pkg::tcap_scheme_t scheme_active,
  output logic polarity_active_low
);

  // positions of the single pins above the combined attach field
  localparam int SYNC_W = NUM_PORTS + `TCAP_SINGLE_PINS;
  localparam int POS_ORIENT = NUM_PORTS + `TCAP_POS_ORIENT;
  localparam int POS_A = NUM_PORTS + `TCAP_POS_A_ATTACH;
  localparam int POS_B = NUM_PORTS + `TCAP_POS_B_ATTACH;
  localparam int POS_POL = NUM_PORTS + `TCAP_POS_POLARITY;
  localparam int POS_SCHEME = NUM_PORTS + `TCAP_POS_SCHEME;

  // synchronised pin levels
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_sync;
  logic [NUM_PORTS-1:0] s_combined;
  logic s_orient;
  logic s_a_attach;
  logic s_b_attach;
  logic s_polarity;
  logic s_scheme;

  // decoded, polarity-corrected levels
  logic active_low;
  logic use_per_orient;
  logic [NUM_PORTS-1:0] comb_attached;
  logic orient_is_b;
  logic a_attached;
  logic b_attached;

  // per-scheme enables
  logic [NUM_PORTS-1:0] comb_port_en;
  logic comb_a_en;
  logic comb_b_en;
  logic [NUM_PORTS-1:0] alt_port_en;
  logic alt_a_en;
  logic alt_b_en;

  // next values
  logic [NUM_PORTS-1:0] nxt_port_phy_en;
  logic nxt_orient_a_phy_en;
  logic nxt_orient_b_phy_en;
  tcap_pkg::tcap_scheme_t nxt_scheme;

  // registered outputs
  logic [NUM_PORTS-1:0] port_phy_en_ff;
  logic orient_a_phy_en_ff;
  logic orient_b_phy_en_ff;
  tcap_pkg::tcap_scheme_t scheme_ff;
  logic polarity_ff;

  // every pin and strap crosses in here before any decode; the synchroniser
  // resets to the pull-down level, so an open strap and an idle pin read low
  assign pins_raw = {
    per_orientation_scheme_sel,
    attach_polarity_strap,
    orient_b_attach_in,
    orient_a_attach_in,
    orientation_sel_in,
    combined_attach_in
  };

  tcap_sync #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  ); // [RULE11] [RULE7] [RULE8]

  assign s_combined = pins_sync[NUM_PORTS-1:0];
  assign s_orient = pins_sync[POS_ORIENT];
  assign s_a_attach = pins_sync[POS_A];
  assign s_b_attach = pins_sync[POS_B];
  assign s_polarity = pins_sync[POS_POL];
  assign s_scheme = pins_sync[POS_SCHEME];

  // polarity: one strap flips the meaning of every attach and orientation pin
  assign active_low = (s_polarity == `TCAP_POLARITY_LOW_LVL); // [RULE5] [RULE6] [RULE7]
  assign comb_attached = s_combined ^ {NUM_PORTS{active_low}}; // [RULE5] [RULE6]
  assign orient_is_b = s_orient ^ active_low; // [RULE5] [RULE6]
  assign a_attached = s_a_attach ^ active_low; // [RULE5] [RULE6]
  // polarity-corrected b input drives the b phy, keeping the mapping symmetric with a
  assign b_attached = s_b_attach ^ active_low; // [RULE6]

  // scheme select
  assign use_per_orient = (s_scheme == `TCAP_SCHEME_PER_ORIENT_LVL); // [RULE1] [RULE2] [RULE8]

  // combined scheme: each attach pin powers its own port; on the oriented
  // port the orientation level chooses which of the two phys comes up
  assign comb_port_en = comb_attached; // [RULE9]
  assign comb_a_en = comb_attached[ORIENT_PORT] & ~orient_is_b; // [RULE10]
  assign comb_b_en = comb_attached[ORIENT_PORT] & orient_is_b; // [RULE10]

  // per-orientation scheme: only the oriented port can come up, and the two
  // attach pins drive their phys independently
  assign alt_a_en = a_attached; // [RULE3]
  assign alt_b_en = b_attached; // [RULE4]

  // every other port stays dark, whatever its combined attach pin shows
  for (genvar gi = 0; gi < NUM_PORTS; gi++)
  begin : g_alt_port
    if (gi == ORIENT_PORT)
    begin : g_oriented
      assign alt_port_en[gi] = alt_a_en | alt_b_en; // [RULE3] [RULE4]
    end
    else
    begin : g_dark
      assign alt_port_en[gi] = `TCAP_PHY_OFF; // [RULE2]
    end
  end

  // the unused scheme's pins are simply not selected, so they cannot leak in
  assign nxt_port_phy_en = use_per_orient ? alt_port_en : comb_port_en; // [RULE1] [RULE2]
  assign nxt_orient_a_phy_en = use_per_orient ? alt_a_en : comb_a_en; // [RULE1] [RULE2]
  assign nxt_orient_b_phy_en = use_per_orient ? alt_b_en : comb_b_en; // [RULE1] [RULE2]
  assign nxt_scheme = use_per_orient ? tcap_pkg::TCAP_SCHEME_PER_ORIENT
                                     : tcap_pkg::TCAP_SCHEME_COMBINED;

  // output stage: phys are held off throughout reset; one short block per
  // output keeps each reset value beside its own register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_phy_en_ff <= {NUM_PORTS{`TCAP_PHY_OFF}}; // [RULE11]
    end
    else
    begin
      port_phy_en_ff <= nxt_port_phy_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      orient_a_phy_en_ff <= `TCAP_PHY_OFF; // [RULE11]
    end
    else
    begin
      orient_a_phy_en_ff <= nxt_orient_a_phy_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      orient_b_phy_en_ff <= `TCAP_PHY_OFF; // [RULE11]
    end
    else
    begin
      orient_b_phy_en_ff <= nxt_orient_b_phy_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scheme_ff <= tcap_pkg::TCAP_SCHEME_COMBINED;
    end
    else
    begin
      scheme_ff <= nxt_scheme;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      polarity_ff <= `TCAP_PIN_RST_VAL;
    end
    else
    begin
      polarity_ff <= active_low;
    end
  end

  assign port_phy_en = port_phy_en_ff;
  assign orient_a_phy_en = orient_a_phy_en_ff;
  assign orient_b_phy_en = orient_b_phy_en_ff;
  assign scheme_active = scheme_ff;
  assign polarity_active_low = polarity_ff;

endmodule // tcap_phy_enable

/* File: inc/tcap_consts.svh */
// constants for the type-c attach phy enable block
`ifndef TCAP_CONSTS_SVH
`define TCAP_CONSTS_SVH

// number of ports fed by the combined attach inputs
`define TCAP_NUM_PORTS 3
// port index steered by the orientation input and the per-orientation inputs
`define TCAP_ORIENT_PORT 1
// synchroniser depth, in flip-flops
`define TCAP_SYNC_STAGES 2
// single pins, counted upwards from the top of the combined attach field
`define TCAP_POS_ORIENT 0
`define TCAP_POS_A_ATTACH 1
`define TCAP_POS_B_ATTACH 2
`define TCAP_POS_POLARITY 3
`define TCAP_POS_SCHEME 4
// number of single pins carried above the combined attach field
`define TCAP_SINGLE_PINS 5
// value taken by synchronised pins and straps under reset (pull-down level)
`define TCAP_PIN_RST_VAL 1'b0
// phy enable value while off
`define TCAP_PHY_OFF 1'b0
// strap level that selects the per-orientation scheme
`define TCAP_SCHEME_PER_ORIENT_LVL 1'b1
// strap level that selects active-low signalling
`define TCAP_POLARITY_LOW_LVL 1'b1

`endif

/* File: inc/tcap_pkg.sv */
// types shared by the type-c attach phy enable block
package tcap_pkg;

  // control scheme in force, one-hot
  typedef enum logic [1:0] {
    TCAP_SCHEME_COMBINED = 2'h1,
    TCAP_SCHEME_PER_ORIENT = 2'h2
  } tcap_scheme_t;

endpackage

/* File: hdl/tcap_sync.sv */
// multi-bit two-flop level synchroniser for pins and straps
`timescale 1ns/1ns
`include "tcap_consts.svh"

module tcap_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // levels from outside the clock domain
  input wire logic [WIDTH-1:0] async_in,
  // synchronised levels
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // bits are independent levels; no bus coherence is implied across them
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= {WIDTH{`TCAP_PIN_RST_VAL}};
      sync_ff <= {WIDTH{`TCAP_PIN_RST_VAL}};
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // tcap_sync

/* File: test/tcap_cc_model.sv */
// far-side cc controller model: encodes attach state onto pin levels
`timescale 1ns/1ns
module tcap_cc_model (
  // logical attach state and polarity strap
  input wire logic pol,
  input wire logic [5:0] st,
  // pin levels seen by the hub
  output logic [5:0] pins
);
  // the controller drives levels only, so a strap flip re-encodes at once
  assign pins = st ^ {6{pol}};
endmodule // tcap_cc_model

/* File: test/tcap_phy_enable_monitor.sv */
// assertion checker for the type-c phy enable block
`timescale 1ns/1ns
module tcap_phy_enable_monitor #(
  parameter int NUM_PORTS = 3,
  parameter int ORIENT_PORT = 1
) (
  // clock, reset and straps
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic attach_polarity_strap,
  input wire logic per_orientation_scheme_sel,
  // attach pins
  input wire logic [NUM_PORTS-1:0] combined_attach_in,
  input wire logic orientation_sel_in,
  input wire logic orient_a_attach_in,
  input wire logic orient_b_attach_in,
  // outputs
  input wire logic [NUM_PORTS-1:0] port_phy_en,
  input wire logic orient_a_phy_en,
  input wire logic orient_b_phy_en,
  input wire tcap_pkg::tcap_scheme_t scheme_active,
  input wire logic polarity_active_low
);
  // pins delayed by the three-edge crossing latency
  logic [NUM_PORTS+4:0] d1_ff, d2_ff, d3_ff;
  logic [2:0] warm_ff;
  always_ff @(posedge sys_clk)
  begin
    d1_ff <= {attach_polarity_strap, per_orientation_scheme_sel, orientation_sel_in,
      orient_a_attach_in, orient_b_attach_in, combined_attach_in};
    d2_ff <= d1_ff;
    d3_ff <= d2_ff;
  end
  // pipeline holds pre-reset pins for three edges after release; one edge
  // of margin because the disable term is read unsampled
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      warm_ff <= 3'h0;
    else if (warm_ff != 3'h4)
      warm_ff <= warm_ff + 3'h1;
  end
  wire logic p = d3_ff[NUM_PORTS+4];
  wire logic s = d3_ff[NUM_PORTS+3];
  wire logic o = d3_ff[NUM_PORTS+2] ^ p;
  wire logic a = d3_ff[NUM_PORTS+1] ^ p;
  wire logic b = d3_ff[NUM_PORTS] ^ p;
  wire logic [NUM_PORTS-1:0] c = d3_ff[NUM_PORTS-1:0] ^ {NUM_PORTS{p}};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn || warm_ff != 3'h4);
  chk_comb_port_en: assert property (!s |-> port_phy_en == c)
    else $error("combined port enable wrong");
  chk_comb_phy_a: assert property (!s |-> orient_a_phy_en == (c[ORIENT_PORT] && !o))
    else $error("combined a enable wrong");
  chk_comb_phy_b: assert property (!s |-> orient_b_phy_en == (c[ORIENT_PORT] && o))
    else $error("combined b enable wrong");
  chk_orient_a_phy: assert property (s |-> orient_a_phy_en == a)
    else $error("orientation a enable wrong");
  chk_orient_b_phy: assert property (s |-> orient_b_phy_en == b)
    else $error("orientation b enable wrong");
  chk_orient_port_en: assert property (s |-> port_phy_en == (NUM_PORTS'(a | b) << ORIENT_PORT))
    else $error("per-orientation port enable wrong");
  chk_scheme_shown: assert property (scheme_active == (s ? 2'h2 : 2'h1))
    else $error("scheme status wrong");
  chk_polarity_shown: assert property (polarity_active_low == p)
    else $error("polarity status wrong");
  chk_reset_off: assert property (disable iff (1'b0) !rstn |-> port_phy_en == '0 && !orient_a_phy_en && !orient_b_phy_en)
    else $error("phy on in reset");
  cover property (!s && o && c[ORIENT_PORT]);
  cover property (s && a && b);
  cover property (p && !s && c != '0);
endmodule // tcap_phy_enable_monitor
bind tcap_phy_enable tcap_phy_enable_monitor #(.NUM_PORTS(NUM_PORTS), .ORIENT_PORT(ORIENT_PORT))
  tcap_phy_enable_monitor_i (.*);

/* File: test/test_tcap_phy_enable.sv */
// self-checking bench for the type-c phy enable block
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin err_total++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module test_tcap_phy_enable;
  logic sys_clk = 1'b0;
  logic rstn = 1'b1;
  logic pol = 1'b0;
  logic sel = 1'b0;
  logic [5:0] st = 6'h00;
  logic [5:0] pins;
  logic [2:0] port_en;
  logic en_a, en_b, lo;
  tcap_pkg::tcap_scheme_t sch;
  int err_total = 0;
  int cmp_count = 0;
  always #10 sys_clk = ~sys_clk;
  tcap_cc_model tcap_cc_model_i (.pol(pol), .st(st), .pins(pins));
  tcap_phy_enable tcap_phy_enable_i (.sys_clk(sys_clk), .rstn(rstn),
    .attach_polarity_strap(pol), .per_orientation_scheme_sel(sel),
    .combined_attach_in(pins[2:0]), .orientation_sel_in(pins[3]),
    .orient_a_attach_in(pins[4]), .orient_b_attach_in(pins[5]), .port_phy_en(port_en),
    .orient_a_phy_en(en_a), .orient_b_phy_en(en_b), .scheme_active(sch),
    .polarity_active_low(lo));
  // {port enables, a, b} from logical attach state, orientation port 1
  function automatic logic [4:0] expect_en(logic s, logic [5:0] v);
    if (s)
      return {1'b0, v[4] | v[5], 1'b0, v[4], v[5]};
    return {v[2:0], v[1] & !v[3], v[1] & v[3]};
  endfunction
  task automatic check_all(logic [4:0] e);
    `CHK("port_en", e[4:2], port_en)
    `CHK("phy_a", e[1], en_a)
    `CHK("phy_b", e[0], en_b)
    `CHK("scheme", sel ? 2'h2 : 2'h1, sch)
    `CHK("pol_low", pol, lo)
  endtask
  task automatic apply(logic p, logic s, logic [5:0] v);
    @(negedge sys_clk);
    pol = p;
    sel = s;
    st = v;
    repeat (3) @(negedge sys_clk);
    check_all(expect_en(s, v));
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h491B2306));
    #1 rstn = 1'b0;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    apply(1'b0, 1'b0, 6'h00);
    for (int k = 0; k < 4; k++)
    begin
      apply(k[0], k[1], 6'h3F);
      apply(k[0], k[1], 6'h0A);
      apply(k[0], k[1], 6'h12);
    end
    apply(1'b0, 1'b0, 6'h3F);
    rstn = 1'b0;
    @(negedge sys_clk);
    check_all(5'h00);
    rstn = 1'b1;
    repeat (200)
      apply(1'($urandom), 1'($urandom), 6'($urandom));
    report_and_stop;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop;
  end
endmodule // test_tcap_phy_enable
